// [rtl/cps_sequencer.sv]
// How it works
// - Reset restores every register, bus then ready
// - Battery only: switch closed, regulator off
// - Overcurrent opens switch, sets off flag
// - Regulator, qualify, detect, voltage limit, converter
// - Detection and limit precede converter start
// - Regulator after input valid plus 220 ms
// - Any condition missing: stay off, battery feeds
// - Qualify below overvoltage, above minimum under load
// - Pass sets input good, pulses event
// - Failed qualification retried every 2 s
// - Detection updates limit, power good, event
// - Applied limit is minimum of setting, pin
// - Detection disabled keeps limit, type, status
// - Select high 500 mA/001, low 3.25 A/010
// - Force bit reruns detection, clears when done
// - Overvoltage held 1 us stops charging
// - Current pulses timed within their windows
// - Battery, system codes: 2.304 V + 20 mV
// - Charge 50 mA steps; input 2.6 V + 100 mV
// - Wake held about a second exits ship mode
// - Wake held about 19.5 s: reset, switch open
// - Voltage limit set pulses event
// - System below 2.2 V caps at 200 mA
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
module cps_sequencer
  import cps_pkg::*;
#(
  parameter int unsigned REG_WAIT_CYC = REG_WAIT_MS * CYC_PER_MS,
  parameter int unsigned QUAL_CYC = QUAL_MS * CYC_PER_MS,
  parameter int unsigned RETRY_CYC = RETRY_MS * CYC_PER_MS,
  parameter int unsigned PUMP_LONG_CYC =
    (PUMP_LONG_MIN_MS + PUMP_LONG_MAX_MS) / 2 * CYC_PER_MS,
  parameter int unsigned PUMP_SHORT_CYC =
    (PUMP_SHORT_MIN_MS + PUMP_SHORT_MAX_MS) / 2 * CYC_PER_MS,
  parameter int unsigned PUMP_STOP_CYC =
    (PUMP_STOP_MIN_MS + PUMP_STOP_MAX_MS) / 2 * CYC_PER_MS,
  parameter int unsigned PUMP_DLY_CYC =
    (PUMP_DLY_MIN_MS + PUMP_DLY_MAX_MS) / 2 * CYC_PER_MS,
  parameter int unsigned SHIP_CYC =
    (SHIP_MIN_MS + SHIP_MAX_MS) / 2 * CYC_PER_MS,
  parameter int unsigned FULL_RST_CYC =
    (FULL_RST_MIN_MS + FULL_RST_MAX_MS) / 2 * CYC_PER_MS,
  parameter int unsigned BATOFF_CYC =
    (BATOFF_MIN_MS + BATOFF_MAX_MS) / 2 * CYC_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cps_sense_t sense,
  input wire cps_adc_t adc,
  input wire logic source_select_pin,
  input wire logic [5:0] external_current_limit_pin,
  input wire logic wake_button_input_n,
  output logic internal_regulator_en,
  output logic test_load_en,
  output logic converter_en,
  output logic charge_en,
  output logic battery_switch_on,
  output logic power_good_pin_n,
  output logic event_n,
  output logic adapter_current_pulse,
  output logic system_reset,
  output logic [5:0] applied_limit
);

  if (PUMP_SHORT_CYC < 1 || PUMP_LONG_CYC < 1 || PUMP_STOP_CYC < 1 ||
      PUMP_DLY_CYC < 1) begin : g_chk
    $error("cps_sequencer: pulse times below one cycle");
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  cps_state_t state;
  cps_state_t next_state;
  logic auto_source_detect_enable;
  logic force_source_redetect;
  logic high_impedance_request;
  logic charge_enable;
  logic [5:0] input_current_limit_setting;
  logic [2:0] source_type_code;
  logic detection_status_bit;
  logic input_good_flag;
  logic power_good_flag;
  logic battery_switch_off_flag;
  logic next_off_flag;
  logic vbus_ok;
  logic hiz;
  logic qual_ok;
  logic do_detect;
  logic wait_done;
  logic qual_done;
  logic retry_done;
  logic ovp_done;
  logic ship_done;
  logic full_done;
  logic batoff_done;
  logic ship_done_q;
  logic full_done_q;
  logic rst_win;
  logic wr;
  logic wr_ctrl;
  logic evt_qual;
  logic evt_det;
  logic evt_vlim;
  logic [2:0] pending;
  logic [7:0] pulse_cnt;
  logic pump_busy;
  logic [31:0] pump_cnt;
  logic [31:0] pump_tgt;
  logic pump_stop;
  logic [5:0] lim_a;
  logic [31:0] rd_word;
  logic rd_err;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus, zero wait states

  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign wr_ctrl = wr && (paddr == ADDR_CTRL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_source_detect_enable <= CTRL_RST[CTRL_AUTO];
      high_impedance_request <= CTRL_RST[CTRL_HIZ];
      charge_enable <= CTRL_RST[CTRL_CHG];
    end else if (wr_ctrl) begin
      auto_source_detect_enable <= pwdata[CTRL_AUTO];
      high_impedance_request <= pwdata[CTRL_HIZ];
      charge_enable <= pwdata[CTRL_CHG];
    end
  end

  // Host set wins over the clear at detection end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_source_redetect <= CTRL_RST[CTRL_FORCE];
    end else begin
      force_source_redetect <= (force_source_redetect && !evt_det) ||
                               (wr_ctrl && pwdata[CTRL_FORCE]);
    end
  end

  function automatic logic [15:0] scale(input logic [6:0] code,
                                        input logic [15:0] ofs,
                                        input logic [15:0] step);
    logic [31:0] prod;
    prod = {25'h0, code} * {16'h0, step};
    return 16'(prod) + ofs;
  endfunction : scale

  always_comb begin
    rd_word = 32'h0;
    rd_err = 1'b0;
    unique case (paddr)
      ADDR_CTRL: rd_word = {28'h0, charge_enable, high_impedance_request,
                            force_source_redetect,
                            auto_source_detect_enable};
      ADDR_EXTERNAL_CURRENT_LIMIT_PIN: rd_word = {26'h0, input_current_limit_setting};
      ADDR_STATUS: rd_word = {16'h0, state, pump_busy, ovp_done,
                              battery_switch_off_flag, detection_status_bit,
                              source_type_code, power_good_flag,
                              input_good_flag};
      ADDR_PUMP: rd_word = {31'h0, pump_busy};
      ADDR_ADC0: rd_word = {scale(adc.sys, BAT_OFS_MV, BAT_STEP_MV),
                            scale(adc.bat, BAT_OFS_MV, BAT_STEP_MV)};
      ADDR_ADC1: rd_word = {scale(adc.ichg, 16'h0000, ICHG_STEP_MA),
                            scale(adc.vbus, VBUS_OFS_MV,
                                  VBUS_STEP_MV)};
      ADDR_APPLIED: rd_word = {26'h0, applied_limit};
      default: rd_err = 1'b1;
    endcase
  end

  // Read data captured in the setup cycle, stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rd_word;
      pslverr <= rd_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up sequence

  assign vbus_ok = sense.vbus_above_uvlo &&
                   (sense.boost_mode ? !sense.vbus_above_bat_sleep
                                     : sense.vbus_above_bat_sleep);
  assign hiz = !vbus_ok || high_impedance_request;
  assign qual_ok = sense.vbus_below_ov && sense.vbus_above_min;
  assign do_detect = auto_source_detect_enable || force_source_redetect;

  cps_timer #(.LIMIT(REG_WAIT_CYC)) u_wait (.pclk(pclk), .presetn(presetn),
    .run(state == ST_WAIT), .done(wait_done));
  cps_timer #(.LIMIT(QUAL_CYC)) u_qual (.pclk(pclk), .presetn(presetn),
    .run(state == ST_QUAL), .done(qual_done));
  cps_timer #(.LIMIT(RETRY_CYC)) u_retry (.pclk(pclk), .presetn(presetn),
    .run(state == ST_RETRY), .done(retry_done));

  always_comb begin
    next_state = state;
    unique case (state)
      ST_HIZ: if (!hiz) next_state = ST_WAIT;
      ST_WAIT: if (wait_done) next_state = ST_QUAL;
      ST_QUAL: if (qual_done) begin
        next_state = qual_ok ? ST_DETECT : ST_RETRY;
      end
      ST_RETRY: if (retry_done) next_state = ST_QUAL;
      ST_DETECT: next_state = ST_VLIM;
      ST_VLIM: next_state = ST_RUN;
      ST_RUN: if (force_source_redetect) next_state = ST_DETECT;
      default: next_state = ST_HIZ;
    endcase
    if (hiz) begin
      next_state = ST_HIZ;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_HIZ;
    end else begin
      state <= next_state;
    end
  end

  assign evt_qual = (state == ST_QUAL) && qual_done && qual_ok && !hiz;
  assign evt_det = (state == ST_DETECT) && do_detect && !hiz;
  assign evt_vlim = (state == ST_VLIM) && !hiz;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_good_flag <= 1'b0;
      power_good_flag <= 1'b0;
    end else if (state == ST_HIZ) begin
      input_good_flag <= 1'b0;
      power_good_flag <= 1'b0;
    end else begin
      if (evt_qual) input_good_flag <= 1'b1;
      if (evt_det) power_good_flag <= 1'b1;
    end
  end

  // Detection result; skipped entirely when not enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_type_code <= TYPE_NONE;
      detection_status_bit <= 1'b0;
    end else if (evt_det) begin
      source_type_code <= source_select_pin ? TYPE_SDP : TYPE_DCP;
      detection_status_bit <= 1'b1;
    end
  end

  // Detection overrides a host write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_current_limit_setting <= EXTERNAL_CURRENT_LIMIT_PIN_RST;
    end else if (evt_det) begin
      input_current_limit_setting <= source_select_pin ? EXTERNAL_CURRENT_LIMIT_PIN_500MA
                                                       : EXTERNAL_CURRENT_LIMIT_PIN_3250MA;
    end else if (wr && paddr == ADDR_EXTERNAL_CURRENT_LIMIT_PIN) begin
      input_current_limit_setting <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_regulator_en <= 1'b0;
      test_load_en <= 1'b0;
      converter_en <= 1'b0;
      power_good_pin_n <= 1'b1;
    end else begin
      internal_regulator_en <= !(next_state inside {ST_HIZ, ST_WAIT});
      test_load_en <= next_state == ST_QUAL;
      // Drops with the input at once, not one cycle late
      converter_en <= (state == ST_RUN) && !hiz;
      power_good_pin_n <= !power_good_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current limit and charge stop

  assign lim_a = (input_current_limit_setting < external_current_limit_pin)
                 ? input_current_limit_setting
                 : external_current_limit_pin;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_limit <= EXTERNAL_CURRENT_LIMIT_PIN_200MA;
      charge_en <= 1'b0;
    end else begin
      applied_limit <= (sense.sys_below_2v2 && lim_a > EXTERNAL_CURRENT_LIMIT_PIN_200MA)
                       ? EXTERNAL_CURRENT_LIMIT_PIN_200MA : lim_a;
      charge_en <= charge_enable && (state == ST_RUN) && !ovp_done;
    end
  end

  cps_timer #(.LIMIT(OVP_CYC)) u_ovp (.pclk(pclk), .presetn(presetn),
    .run(sense.bat_ovp), .done(ovp_done));

  ////////////////////////////////////////////////////////////////////////////
  // Battery switch, wake button

  cps_timer #(.LIMIT(SHIP_CYC)) u_ship (.pclk(pclk), .presetn(presetn),
    .run(!wake_button_input_n), .done(ship_done));
  cps_timer #(.LIMIT(FULL_RST_CYC)) u_full (.pclk(pclk), .presetn(presetn),
    .run(!wake_button_input_n), .done(full_done));
  cps_timer #(.LIMIT(BATOFF_CYC)) u_batoff (.pclk(pclk), .presetn(presetn),
    .run(rst_win), .done(batoff_done));

  // Overcurrent set wins over attach or wake clear
  assign next_off_flag = sense.bat_ocp ||
                         (battery_switch_off_flag && !sense.vbus_above_uvlo &&
                          !(ship_done && !ship_done_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_switch_off_flag <= 1'b0;
      ship_done_q <= 1'b0;
      full_done_q <= 1'b0;
      rst_win <= 1'b0;
    end else begin
      battery_switch_off_flag <= next_off_flag;
      ship_done_q <= ship_done;
      full_done_q <= full_done;
      if (full_done && !full_done_q) begin
        rst_win <= 1'b1;
      end else if (batoff_done) begin
        rst_win <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_switch_on <= 1'b0;
      system_reset <= 1'b0;
    end else begin
      battery_switch_on <= sense.bat_above_dpl && !next_off_flag &&
                           !rst_win;
      system_reset <= rst_win;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event pulses: queued, fixed width, gap equal to width

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 3'h0;
      pulse_cnt <= 8'h00;
      event_n <= 1'b1;
    end else begin
      pending <= pending + 3'(evt_qual || evt_det || evt_vlim) -
                 3'(pulse_cnt == 8'h00 && pending != 3'h0);
      if (pulse_cnt != 8'h00) begin
        pulse_cnt <= pulse_cnt - 8'h01;
        if (pulse_cnt == EVT_W_CYC) event_n <= 1'b1;
      end else if (pending != 3'h0) begin
        pulse_cnt <= 8'((EVT_W_CYC << 1) - 8'h01);
        event_n <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Adapter current pulses; a request while busy is ignored

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_busy <= 1'b0;
      adapter_current_pulse <= 1'b0;
      pump_cnt <= 32'h0;
      pump_tgt <= 32'h0;
      pump_stop <= 1'b0;
    end else if (!pump_busy) begin
      if (wr && paddr == ADDR_PUMP && pwdata[1:0] != 2'h0) begin
        pump_busy <= 1'b1;
        adapter_current_pulse <= 1'b1;
        pump_cnt <= 32'h1;
        pump_stop <= pwdata[1:0] == PUMP_STOP;
        unique case (pwdata[1:0])
          PUMP_LONG: pump_tgt <= PUMP_LONG_CYC;
          PUMP_SHORT: pump_tgt <= PUMP_SHORT_CYC;
          default: pump_tgt <= PUMP_STOP_CYC;
        endcase
      end
    end else if (pump_cnt != pump_tgt) begin
      pump_cnt <= pump_cnt + 32'h1;
    end else if (adapter_current_pulse) begin
      adapter_current_pulse <= 1'b0;
      pump_cnt <= 32'h1;
      pump_tgt <= pump_stop ? PUMP_DLY_CYC : PUMP_SHORT_CYC;
    end else begin
      pump_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] ovp_run;
  localparam int OVP_CHK = OVP_CYC;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovp_run <= 8'h00;
    end else if (!sense.bat_ovp) begin
      ovp_run <= 8'h00;
    end else if (ovp_run != 8'hFF) begin
      ovp_run <= ovp_run + 8'h01;
    end
  end

  reg_wait_a: assert property (
    $rose(internal_regulator_en) |-> $past(state) == ST_WAIT)
    else $error("regulator enabled outside the wait end");
  hiz_off_a: assert property (
    hiz |=> !internal_regulator_en && !converter_en)
    else $error("regulator on while input invalid");
  conv_order_a: assert property (
    $rose(converter_en) |-> $past(state, 2) == ST_VLIM)
    else $error("converter started out of order");
  qual_flag_a: assert property (
    evt_qual |=> input_good_flag ##[1:3] !event_n)
    else $error("qualification pass not flagged");
  qual_retry_a: assert property (
    state == ST_QUAL && qual_done && !qual_ok && !hiz |=>
      state == ST_RETRY)
    else $error("failed qualification not retried");
  det_limit_a: assert property (
    evt_det && source_select_pin |=>
      input_current_limit_setting == EXTERNAL_CURRENT_LIMIT_PIN_500MA &&
      source_type_code == TYPE_SDP)
    else $error("host port detection result wrong");
  det_keep_a: assert property (
    state == ST_DETECT && !do_detect |=>
      $stable(source_type_code) && $stable(detection_status_bit))
    else $error("detection result changed while disabled");
  force_clr_a: assert property (
    evt_det && !wr_ctrl |=> !force_source_redetect)
    else $error("force bit not cleared after detection");
  min_limit_a: assert property (
    ##1 applied_limit <= $past(input_current_limit_setting) &&
      applied_limit <= $past(external_current_limit_pin))
    else $error("applied limit above setting or pin");
  start_cap_a: assert property (
    sense.sys_below_2v2 |=> applied_limit <= EXTERNAL_CURRENT_LIMIT_PIN_200MA)
    else $error("start-up cap not applied");
  ovp_stop_a: assert property (
    ovp_run > OVP_CHK |-> !charge_en)
    else $error("charging during battery overvoltage");
  ocp_open_a: assert property (
    sense.bat_ocp |=> battery_switch_off_flag && !battery_switch_on)
    else $error("battery switch not opened on overcurrent");
  evt_width_a: assert property (
    $fell(event_n) |=> !event_n [*7] ##1 event_n [*8])
    else $error("event pulse width or gap wrong");

endmodule : cps_sequencer

// [rtl/cps_pkg.sv]
package cps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing figures
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned REG_WAIT_MS = 220;
  localparam int unsigned QUAL_MS = 30;
  localparam int unsigned RETRY_MS = 2000;
  localparam int unsigned OVP_DEGLITCH_NS = 1000;
  localparam int unsigned OVP_CYC =
    (OVP_DEGLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PUMP_LONG_MIN_MS = 240;
  localparam int unsigned PUMP_LONG_MAX_MS = 360;
  localparam int unsigned PUMP_SHORT_MIN_MS = 70;
  localparam int unsigned PUMP_SHORT_MAX_MS = 130;
  localparam int unsigned PUMP_STOP_MIN_MS = 430;
  localparam int unsigned PUMP_STOP_MAX_MS = 570;
  localparam int unsigned PUMP_DLY_MIN_MS = 80;
  localparam int unsigned PUMP_DLY_MAX_MS = 225;
  localparam int unsigned SHIP_MIN_MS = 900;
  localparam int unsigned SHIP_MAX_MS = 1300;
  localparam int unsigned FULL_RST_MIN_MS = 16_000;
  localparam int unsigned FULL_RST_MAX_MS = 23_000;
  localparam int unsigned BATOFF_MIN_MS = 250;
  localparam int unsigned BATOFF_MAX_MS = 400;
  localparam logic [7:0] EVT_W_CYC = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, fields and reset values
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EXTERNAL_CURRENT_LIMIT_PIN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PUMP = 8'h0C;
  localparam logic [7:0] ADDR_ADC0 = 8'h10;
  localparam logic [7:0] ADDR_ADC1 = 8'h14;
  localparam logic [7:0] ADDR_APPLIED = 8'h18;
  localparam int unsigned CTRL_AUTO = 0;
  localparam int unsigned CTRL_FORCE = 1;
  localparam int unsigned CTRL_HIZ = 2;
  localparam int unsigned CTRL_CHG = 3;
  localparam logic [3:0] CTRL_RST = 4'h9;
  localparam logic [5:0] EXTERNAL_CURRENT_LIMIT_PIN_200MA = 6'h02;
  localparam logic [5:0] EXTERNAL_CURRENT_LIMIT_PIN_500MA = 6'h08;
  localparam logic [5:0] EXTERNAL_CURRENT_LIMIT_PIN_3250MA = 6'h3F;
  localparam logic [5:0] EXTERNAL_CURRENT_LIMIT_PIN_RST = 6'h08;
  localparam logic [2:0] TYPE_NONE = 3'h0;
  localparam logic [2:0] TYPE_SDP = 3'h1;
  localparam logic [2:0] TYPE_DCP = 3'h2;
  localparam logic [1:0] PUMP_LONG = 2'h1;
  localparam logic [1:0] PUMP_SHORT = 2'h2;
  localparam logic [1:0] PUMP_STOP = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Converter code scaling
  localparam logic [15:0] BAT_OFS_MV = 16'h0900;
  localparam logic [15:0] BAT_STEP_MV = 16'h0014;
  localparam logic [15:0] VBUS_OFS_MV = 16'h0A28;
  localparam logic [15:0] VBUS_STEP_MV = 16'h0064;
  localparam logic [15:0] ICHG_STEP_MA = 16'h0032;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [6:0] {
    ST_HIZ = 7'h01,
    ST_WAIT = 7'h02,
    ST_QUAL = 7'h04,
    ST_RETRY = 7'h08,
    ST_DETECT = 7'h10,
    ST_VLIM = 7'h20,
    ST_RUN = 7'h40
  } cps_state_t;

  typedef struct packed {
    logic vbus_above_uvlo;
    logic vbus_above_bat_sleep;
    logic boost_mode;
    logic vbus_below_ov;
    logic vbus_above_min;
    logic bat_above_dpl;
    logic bat_ocp;
    logic bat_ovp;
    logic sys_below_2v2;
  } cps_sense_t;

  typedef struct packed {
    logic [6:0] bat;
    logic [6:0] sys;
    logic [6:0] ichg;
    logic [6:0] vbus;
  } cps_adc_t;

endpackage : cps_pkg

// [rtl/cps_timer.sv]
`timescale 1ns/1ns
module cps_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic done
);

  logic [31:0] cnt;

  if (LIMIT < 1) begin : g_chk
    $error("cps_timer: LIMIT below one cycle");
  end

  // Restarts whenever run drops, so a broken condition starts over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (!run) begin
      cnt <= '0;
    end else if (cnt != LIMIT) begin
      cnt <= cnt + 32'h1;
    end
  end

  assign done = run && (cnt == LIMIT);

endmodule : cps_timer

// [verification/cps_phy_model.sv]
`timescale 1ns/1ns
// PHY side: select level and limit pin change only after an edge
module cps_phy_model (
  input wire logic pclk,
  input wire logic host_port,
  input wire logic [5:0] pin_code,
  output logic source_select_pin,
  output logic [5:0] external_current_limit_pin
);
  always @(posedge pclk) begin
    source_select_pin <= host_port;
    external_current_limit_pin <= pin_code;
  end
endmodule : cps_phy_model

// [verification/testbench.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  import cps_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic host_port, sel_pin, wake_n, reg_en, load_en, conv_en, bsw, pg_n, ev_n;
  logic [5:0] pin_code, external_current_limit_pin_pin, applied;
  logic chg_en, pump, sys_rst;
  cps_sense_t sense;
  cps_adc_t adc;
  int fails, n_checks, cyc, events;
  cps_sequencer #(.REG_WAIT_CYC(20), .QUAL_CYC(20), .RETRY_CYC(40),
    .PUMP_LONG_CYC(30), .PUMP_SHORT_CYC(10), .PUMP_STOP_CYC(50),
    .PUMP_DLY_CYC(16), .SHIP_CYC(50), .FULL_RST_CYC(150),
    .BATOFF_CYC(30)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense(sense), .adc(adc),
    .source_select_pin(sel_pin), .external_current_limit_pin(external_current_limit_pin_pin),
    .wake_button_input_n(wake_n), .internal_regulator_en(reg_en),
    .test_load_en(load_en), .converter_en(conv_en), .charge_en(chg_en),
    .battery_switch_on(bsw), .power_good_pin_n(pg_n), .event_n(ev_n),
    .adapter_current_pulse(pump), .system_reset(sys_rst),
    .applied_limit(applied));
  cps_phy_model phy (.pclk(pclk), .host_port(host_port),
    .pin_code(pin_code), .source_select_pin(sel_pin),
    .external_current_limit_pin(external_current_limit_pin_pin));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(negedge ev_n) events++;
  // Hang guard: whole run needs well under this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    err = pslverr;
    `CHK("pready", 1'b1, pready)
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_conv(input logic v);
    int t;
    t = 0;
    while (conv_en !== v && t < 400) begin @(posedge pclk); t++; end
    `CHK("conv_en", v, conv_en)
  endtask : wait_conv
  task t_reset;
    apb(0, ADDR_CTRL, 0); `CHK("ctrl", {28'h0, CTRL_RST}, rd)
    apb(0, ADDR_EXTERNAL_CURRENT_LIMIT_PIN, 0); `CHK("external_current_limit_pin", {26'h0, EXTERNAL_CURRENT_LIMIT_PIN_RST}, rd)
    apb(0, 8'h1C, 0); `CHK("slverr", 1'b1, err)
    apb(0, ADDR_ADC0, 0); `CHK("adc0", 32'h0900_0964, rd)
    apb(0, ADDR_ADC1, 0); `CHK("adc1", 32'h0064_0B54, rd)
    `CHK("applied", EXTERNAL_CURRENT_LIMIT_PIN_RST, applied)
    sense.sys_below_2v2 <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("cap", EXTERNAL_CURRENT_LIMIT_PIN_200MA, applied)
    sense.sys_below_2v2 <= 1'b0;
    `CHK("bsw", 1'b1, bsw)
    `CHK("reg_en", 1'b0, reg_en)
    $display("test reset done");
  endtask : t_reset
  task t_attach;
    int t;
    sense.vbus_above_uvlo <= 1'b1; sense.vbus_above_bat_sleep <= 1'b1;
    sense.vbus_below_ov <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK("early reg", 1'b0, reg_en)
    t = 0;
    while (reg_en !== 1'b1 && t < 100) begin @(posedge pclk); t++; end
    `CHK("load", 1'b1, load_en)
    repeat (25) @(posedge pclk);
    apb(0, ADDR_STATUS, 0); `CHK("retry", 8'h10, rd[15:8])
    sense.vbus_above_min <= 1'b1;
    wait_conv(1'b1);
    repeat (60) @(posedge pclk);
    `CHK("events", 3, events)
    apb(0, ADDR_STATUS, 0); `CHK("stat", 5'h07, rd[4:0])
    `CHK("pg_n", 1'b0, pg_n)
    $display("test attach done");
  endtask : t_attach
  task t_force;
    host_port <= 1'b0; pin_code <= 6'h10;
    apb(1, ADDR_CTRL, 32'hB);
    repeat (10) @(posedge pclk);
    apb(0, ADDR_CTRL, 0); `CHK("force", 1'b0, rd[1])
    apb(0, ADDR_EXTERNAL_CURRENT_LIMIT_PIN, 0); `CHK("dcp", {26'h0, EXTERNAL_CURRENT_LIMIT_PIN_3250MA}, rd)
    apb(0, ADDR_STATUS, 0); `CHK("type", TYPE_DCP, rd[4:2])
    `CHK("min", 6'h10, applied)
    $display("test force done");
  endtask : t_force
  task t_noauto;
    host_port <= 1'b1;
    apb(1, ADDR_CTRL, 32'h8);
    sense.vbus_above_uvlo <= 1'b0;
    wait_conv(1'b0);
    sense.vbus_above_uvlo <= 1'b1;
    wait_conv(1'b1);
    apb(0, ADDR_STATUS, 0); `CHK("kept", TYPE_DCP, rd[4:2])
    apb(0, ADDR_EXTERNAL_CURRENT_LIMIT_PIN, 0); `CHK("kept", {26'h0, EXTERNAL_CURRENT_LIMIT_PIN_3250MA}, rd)
    `CHK("chg", 1'b1, chg_en)
    sense.bat_ovp <= 1'b1;
    repeat (30) @(posedge pclk);
    `CHK("ovp chg", 1'b0, chg_en)
    sense.bat_ovp <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("chg back", 1'b1, chg_en)
    apb(1, ADDR_CTRL, 32'hC);
    wait_conv(1'b0);
    $display("test no-auto done");
  endtask : t_noauto
  task t_ocp;
    sense.vbus_above_uvlo <= 1'b0;
    sense.bat_ocp <= 1'b1;
    @(posedge pclk);
    sense.bat_ocp <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("bsw off", 1'b0, bsw)
    apb(0, ADDR_STATUS, 0); `CHK("off flag", 1'b1, rd[6])
    wake_n <= 1'b0;
    repeat (60) @(posedge pclk);
    wake_n <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("bsw on", 1'b1, bsw)
    wake_n <= 1'b0;
    repeat (155) @(posedge pclk);
    wake_n <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("sys_rst", 1'b1, sys_rst)
    `CHK("bsw rst", 1'b0, bsw)
    repeat (40) @(posedge pclk);
    `CHK("sys_rst end", 1'b0, sys_rst)
    `CHK("bsw back", 1'b1, bsw)
    $display("test ocp done");
  endtask : t_ocp
  task t_pump;
    apb(1, ADDR_PUMP, 32'h2);
    `CHK("pump", 1'b1, pump)
    repeat (12) @(posedge pclk);
    `CHK("pump off", 1'b0, pump)
    apb(0, ADDR_PUMP, 0); `CHK("busy", 32'h1, rd)
    repeat (6) @(posedge pclk);
    apb(0, ADDR_PUMP, 0); `CHK("idle", 32'h0, rd)
    adc.bat <= 7'h7F;
    apb(0, ADDR_ADC0, 0); `CHK("adc top", 32'h0900_12EC, rd)
    $display("test pump done");
  endtask : t_pump
  task end_sim;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; host_port = 1'b1; wake_n = 1'b1;
    pin_code = 6'h3F; sense = '0; sense.bat_above_dpl = 1'b1;
    adc = {7'h05, 7'h00, 7'h02, 7'h03};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_attach();
    t_force();
    t_noauto();
    t_ocp();
    t_pump();
    end_sim();
  end
endmodule : testbench
